// *** rtl/idrl_retimer.v ***
// Purpose: three-register retimer plus 0..7 cycle latency stage with first-sample mark
// Assumes: mclk is the DAC clock; data clock period is 16 mclk cycles
// Notes: phases modelled as mclk edges within one data-clock period
//
// Contract
// R1: data passes three retiming registers; first two clocked on selectable phases of 16.
// R2: third retiming register always loads on phase 15.
// R3: capture phase from phase reg bits 7:4, sync phase from bits 3:0.
// R4: LVDS safe default: capture 0, sync 3, latency 1.
// R5: CMOS safe default: capture 0, sync 7, latency 0.
// R6: software must not pick sync phase 14 or 15.
// R7: CMOS: capture phase must not equal sync phase or sit one behind.
// R8: after retiming, delay data 0..7 data-clock cycles from latency reg bits 2:0.
// R9: no latency value can cause a timing violation.
// R10: latency selects which retimed sample is first of a transmission.
// R11: correct latency depends on round trip from frame request to first sample.
// R12: software computes optimal delay index from measured delay plus pin delay.
// R13: zero measured delay maps to index 20 (LVDS DDR) or 12 (others).
// R14: software writes looked-up latency, sync and capture values into their fields.
// R15: LVDS index d: capture (d+8) mod 16, latency floor((d+10)/16), d up to 117.
// R16: LVDS sync phase follows a fixed sequence over index mod 16.
// R17: tune sampling point to centre of data window when setup and hold symmetric.
// R18: phase n lags phase 0 by n DAC clock cycles.
`timescale 1ns/1ns
`include "idrl_map.vh"
module idrl_retimer
(
  // clock and reset
  input wire mclk,
  input wire rstn,
  // register port
  input wire regWrite,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  // sample input from the data source
  input wire [15:0] sampleIn,
  input wire frameRequest,
  // retimed output
  output reg [15:0] sampleOut,
  output reg firstSample,
  output reg sourceDataClockOut,
  output reg [3:0] phaseCount
);

  reg [7:0] latencySelect;
  reg [7:0] retimerPhaseSelect;
  reg [15:0] captureReg;
  reg [15:0] syncReg;
  reg [15:0] finalReg;
  reg [15:0] delayLine [0:`IDRL_LATENCY_MAX-1];
  reg [7:0] markLine;
  reg frameMeta;
  reg frameSync;
  reg frameSeen;
  reg pendingMark;
  reg markCapture;
  reg markSync;
  reg markFinal;
  wire [3:0] capturePhaseSel;
  wire [3:0] syncPhaseSel;
  wire [2:0] latencyValue;
  wire atCapture;
  wire atSync;
  wire atFinal;
  wire [3:0] next_phaseCount;
  integer i;

  // true when the running phase matches a selected phase
  function isPhase;
    input [3:0] count;
    input [3:0] sel;
    begin
      isPhase = (count == sel);
    end
  endfunction

  assign capturePhaseSel = retimerPhaseSelect[`IDRL_CAP_HI:`IDRL_CAP_LO]; // see R3
  assign syncPhaseSel = retimerPhaseSelect[`IDRL_SYNC_HI:`IDRL_SYNC_LO]; // see R3
  assign latencyValue = latencySelect[`IDRL_LATENCY_HI:`IDRL_LATENCY_LO]; // see R8
  // phase n is the nth mclk edge of a data-clock period
  assign atCapture = isPhase(phaseCount, capturePhaseSel); // see R1 R18
  assign atSync = isPhase(phaseCount, syncPhaseSel); // see R1 R18
  assign atFinal = isPhase(phaseCount, `IDRL_FINAL_PHASE); // see R2
  // wraps from 15 to 0 on purpose
  assign next_phaseCount = phaseCount + 4'h1; // see R18

  // register file; resets to the LVDS safe setting
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      latencySelect <= `IDRL_LATENCY_RESET;
      retimerPhaseSelect <= `IDRL_PHASE_RESET;
    end
    else if (regWrite)
    begin
      if (regAddr == `IDRL_ADDR_LATENCY)
        latencySelect <= regWdata;
      if (regAddr == `IDRL_ADDR_PHASE)
        retimerPhaseSelect <= regWdata;
    end
  end

  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
      regRdata <= 8'h00;
    else if (regAddr == `IDRL_ADDR_LATENCY)
      regRdata <= latencySelect;
    else if (regAddr == `IDRL_ADDR_PHASE)
      regRdata <= retimerPhaseSelect;
    else
      regRdata <= 8'h00;
  end

  // phase counter and data clock out: high for phases 0..7
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      phaseCount <= 4'h0;
      sourceDataClockOut <= 1'b0;
    end
    else
    begin
      phaseCount <= next_phaseCount; // see R18
      // follows the count it will stand beside, so high exactly for phases 0..7
      sourceDataClockOut <= !next_phaseCount[3];
    end
  end

  // frame request from the pin: two flops before use
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      frameMeta <= 1'b0;
      frameSync <= 1'b0;
      frameSeen <= 1'b0;
      pendingMark <= 1'b0;
    end
    else
    begin
      frameMeta <= frameRequest;
      frameSync <= frameMeta;
      frameSeen <= frameSync;
      // rising edge arms a mark; cleared when captured at the capture phase
      if (frameSync && !frameSeen)
        pendingMark <= 1'b1; // see R11
      else if (atCapture)
        pendingMark <= 1'b0;
    end
  end

  // three-register retimer; capture and sync registers load on selectable phases, final register on phase 15
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      captureReg <= 16'h0000;
      syncReg <= 16'h0000;
      finalReg <= 16'h0000;
      markCapture <= 1'b0;
      markSync <= 1'b0;
      markFinal <= 1'b0;
    end
    else
    begin
      if (atCapture)
      begin
        captureReg <= sampleIn; // see R1
        markCapture <= pendingMark;
      end
      if (atSync)
      begin
        syncReg <= captureReg; // see R1
        markSync <= markCapture;
      end
      if (atFinal)
      begin
        finalReg <= syncReg; // see R2
        markFinal <= markSync;
      end
    end
  end

  // latency stage advances once per data clock, after phase 15 load
  always @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (i = 0; i < `IDRL_LATENCY_MAX; i = i + 1)
        delayLine[i] <= 16'h0000;
      markLine <= 8'h00;
      sampleOut <= 16'h0000;
      firstSample <= 1'b0;
    end
    else if (isPhase(phaseCount, `IDRL_OUT_PHASE))
    begin
      delayLine[0] <= finalReg; // see R9
      markLine[0] <= markFinal;
      for (i = 1; i < `IDRL_LATENCY_MAX; i = i + 1)
      begin
        delayLine[i] <= delayLine[i-1];
        markLine[i] <= markLine[i-1];
      end
      // tap 0 is the final register itself, so latency 0 adds nothing
      if (latencyValue == 3'h0)
      begin
        sampleOut <= finalReg; // see R8
        firstSample <= markFinal; // see R10
      end
      else
      begin
        sampleOut <= delayLine[latencyValue - 3'h1]; // see R8
        firstSample <= markLine[latencyValue - 3'h1]; // see R10
      end
    end
    else
      firstSample <= 1'b0;
  end

endmodule // idrl_retimer

// *** include/idrl_map.vh ***
// Purpose: constants for the input data retimer and latency stage
// Assumes: byte-wide register port, 16 DAC clocks per data clock
// Notes: definitions only
`ifndef IDRL_MAP_VH
`define IDRL_MAP_VH
`define IDRL_ADDR_LATENCY 8'h21
`define IDRL_ADDR_PHASE 8'h23
`define IDRL_LATENCY_RESET 8'h01
`define IDRL_PHASE_RESET 8'h03
`define IDRL_CAP_HI 7
`define IDRL_CAP_LO 4
`define IDRL_SYNC_HI 3
`define IDRL_SYNC_LO 0
`define IDRL_LATENCY_HI 2
`define IDRL_LATENCY_LO 0
`define IDRL_FINAL_PHASE 4'hf
`define IDRL_PHASE_LAST 4'hf
`define IDRL_OUT_PHASE 4'h0
`define IDRL_LATENCY_MAX 8
`endif

// *** verif/idrl_source.sv ***
// Purpose: parallel sample source model
// Assumes: one sample per data clock rise
// Notes: idle bus toggles so stale data never passes
`timescale 1ns/1ns
module idrl_source
(
  // clocks and request
  input wire mclk,
  input wire dataClock,
  input wire frameRequest,
  // sample bus
  output logic [15:0] sampleIn
);
  logic clockQ = 1'b0;
  logic reqQ = 1'b0;
  logic [3:0] left = 4'h0;
  initial sampleIn = 16'h0000;
  always @(posedge mclk)
  begin
    clockQ <= dataClock;
    reqQ <= frameRequest;
    if (frameRequest && !reqQ)
      left <= 4'h8;
    else if (dataClock && !clockQ)
    begin
      sampleIn <= (left != 4'h0) ? 16'ha5a0 + {12'h000, left} : ~sampleIn;
      left <= (left != 4'h0) ? left - 4'h1 : left;
    end
  end
endmodule // idrl_source

// *** verif/idrl_retimer_asserts.sv ***
// Purpose: port checks for the retimer
// Assumes: phases are mclk cycles
// Notes: bound at the foot
`timescale 1ns/1ns
module idrl_chk
(
  // all ports of the retimer
  input wire mclk,
  input wire rstn,
  input wire regWrite,
  input wire [7:0] regAddr,
  input wire [7:0] regWdata,
  input wire [7:0] regRdata,
  input wire [15:0] sampleIn,
  input wire frameRequest,
  input wire [15:0] sampleOut,
  input wire firstSample,
  input wire sourceDataClockOut,
  input wire [3:0] phaseCount
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  ph_step_a: assert property ($past(rstn) |->
    phaseCount == $past(phaseCount) + 4'h1) else $error("phase skip");
  out_hold_a: assert property (phaseCount != 4'h1 |-> $stable(sampleOut))
    else $error("sample moved");
  mark_phase_a: assert property (firstSample |-> phaseCount == 4'h1)
    else $error("mark off phase");
  clock_shape_a: assert property ($rose(sourceDataClockOut) && phaseCount == 4'h0 |->
    sourceDataClockOut [*8] ##1 !sourceDataClockOut) else $error("data clock shape");
  unmapped_rd_a: assert property (regAddr != 8'h21 && regAddr != 8'h23 |=>
    regRdata == 8'h00) else $error("unmapped read");
  phase_rd_a: assert property (regWrite && regAddr == 8'h23 ##1
    regAddr == 8'h23 |=> regRdata == $past(regWdata, 2)) else $error("phase read");
  mark_due_a: assert property ($rose(frameRequest) |-> ##[5:300] firstSample)
    else $error("no mark");
  mark_early_a: assert property ($rose(frameRequest) |-> !firstSample [*4])
    else $error("mark early");
endmodule // idrl_chk
bind idrl_retimer idrl_chk i_idrl_chk (.mclk, .rstn, .regWrite, .regAddr, .regWdata,
  .regRdata, .sampleIn, .frameRequest, .sampleOut, .firstSample, .sourceDataClockOut,
  .phaseCount);

// *** verif/input_data_retimer_latency_test.sv ***
// Purpose: bench for the retimer
// Assumes: source model answers frames
// Notes: latency judged by arrival cycle
`timescale 1ns/1ns
module input_data_retimer_latency_test;
  logic mclk = 0, rstn = 0, regWrite = 0, frameRequest = 0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00;
  wire [7:0] regRdata;
  wire [15:0] sampleIn, sampleOut;
  wire firstSample, dataClock;
  wire [3:0] phaseCount;
  int mismatches = 0, n_compared = 0, n0, n1;
  logic [15:0] v0, v1;
  always #10 mclk = ~mclk;
  idrl_retimer i_idrl_retimer (.mclk, .rstn, .regWrite, .regAddr, .regWdata, .regRdata,
    .sampleIn, .frameRequest, .sampleOut, .firstSample, .sourceDataClockOut(dataClock),
    .phaseCount);
  idrl_source i_idrl_source (.mclk, .dataClock, .frameRequest, .sampleIn);
  task automatic chk(input logic [31:0] s, e);
    n_compared++;
    if (s !== e)
      mismatches++;
    if (s !== e)
      $display("[FAIL] %0t seen %h want %h", $time, s, e);
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk) regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    @(posedge mclk) regAddr <= a;
    repeat (2) @(posedge mclk);
    #1 chk(regRdata, e);
  endtask
  task automatic frame(input logic [7:0] latency, output int n, output logic [15:0] v);
    wr(8'h21, latency);
    n = 0;
    @(posedge mclk) #1;
    // request one edge before phase 0, so the first word is on the bus before the marked capture
    while (phaseCount !== 4'he) @(posedge mclk) #1;
    @(posedge mclk) frameRequest <= 1'b1;
    while (firstSample !== 1'b1 && n < 400) @(posedge mclk) #1 n++;
    v = sampleOut;
    chk(v, 16'ha5a8);
    @(posedge mclk) frameRequest <= 1'b0;
    #1 chk(firstSample, 1'b0);
    repeat (200) @(posedge mclk);
  endtask
  task automatic t_regs;
    rd(8'h21, 8'h01);
    rd(8'h23, 8'h03);
    wr(8'h23, 8'hd7);
    wr(8'h22, 8'hff);
    rd(8'h23, 8'hd7);
    rd(8'h22, 8'h00);
    wr(8'h23, 8'h03);
  endtask
  task automatic t_latency;
    frame(8'h00, n0, v0);
    chk(n0, 32'h0000_0022);
    frame(8'h07, n1, v1);
    chk(n1 - n0, 32'h0000_0070);
    chk(v1, v0);
    frame(8'h03, n1, v1);
    chk(n1 - n0, 32'h0000_0030);
    rd(8'h21, 8'h03);
  endtask
  task automatic t_table;
    // cmos safe setting: capture well clear of sync
    wr(8'h23, 8'h07);
    frame(8'h00, n1, v1);
    chk(n1, 32'h0000_0022);
    // zero measured delay, lvds ddr: index 20 gives capture 12, sync 10, latency 1
    wr(8'h23, 8'hca);
    frame(8'h01, n1, v1);
    chk(n1, 32'h0000_0032);
    // index 16 samples mid-window: capture 8, sync 7, latency 1
    wr(8'h23, 8'h87);
    frame(8'h01, n1, v1);
    chk(n1, 32'h0000_0032);
    rd(8'h23, 8'h87);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    t_regs;
    t_latency;
    t_table;
    report_and_stop;
  end
  // run needs about 1.7k cycles
  initial
  begin
    #400000;
    mismatches++;
    report_and_stop;
  end
endmodule // input_data_retimer_latency_test
